//--- rtl/gpc_port.sv
// Local design decisions: the APB slave port and the register addresses.
`timescale 1ns/1ps
`default_nettype none
module gpc_port (
    input  wire logic                     sys_clk,
    input  wire logic                     rstn,
    input  wire logic                     clk_en,
    input  wire logic                     watchdog_reset_source,
    input  wire logic                     standby,
    input  wire logic                     sleep,
    input  wire logic                     extended_mode,
    input  wire gpc_pkg::gpc_apb_req_type apb_req,
    output gpc_pkg::gpc_apb_rsp_type      apb_rsp,
    input  wire logic [15:0]              pa_in,
    input  wire logic [9:0]               pb_in,
    input  wire logic [15:0]              pc_in,
    input  wire logic [15:0]              pd_in,
    input  wire logic [15:0]              pe_in,
    input  wire logic [7:0]               pf_in,
    input  wire logic [7:0]               adc_sampling,
    output gpc_pkg::gpc_pin16_type        pa_pin,
    output gpc_pkg::gpc_pin10_type        pb_pin,
    output gpc_pkg::gpc_pin16_type        pc_pin,
    output gpc_pkg::gpc_pin16_type        pd_pin,
    output gpc_pkg::gpc_pin16_type        pe_pin
);
    import gpc_pkg::*;

    // **********************************************
    // helpers
    // **********************************************
    function automatic logic [15:0] read_port(input logic [15:0] data,
                                              input logic [15:0] dir,
                                              input logic [15:0] pins);
        read_port = (data & dir) | (pins & ~dir);
    endfunction

    // **********************************************
    // pin synchronisers
    // **********************************************
    logic [15:0] pa_s1, pa_s2, pc_s1, pc_s2, pd_s1, pd_s2, pe_s1, pe_s2;
    logic [9:0]  pb_s1, pb_s2;
    logic [7:0]  pf_s1, pf_s2;
    logic        mode_s1, mode_s2;

    // no reset: port f follows the pins whenever clk_en is set, in reset too
    always_ff @(posedge sys_clk) begin
        if (clk_en) begin
            {pa_s1, pb_s1, pc_s1, pd_s1, pe_s1, pf_s1, mode_s1} <=
                {pa_in, pb_in, pc_in, pd_in, pe_in, pf_in, extended_mode};
            {pa_s2, pb_s2, pc_s2, pd_s2, pe_s2, pf_s2, mode_s2} <=   // RULE11
                {pa_s1, pb_s1, pc_s1, pd_s1, pe_s1, pf_s1, mode_s1};
        end
    end

    // **********************************************
    // bus decode
    // **********************************************
    logic [15:0] a_ctl1, a_ctl2, a_dir, b_dir, c_dir, d_dir, e_dir;
    logic [15:0] a_data, b_data, c_data, d_data, e_data;
    logic [9:0]  b_func;
    logic        ck_div;

    wire [7:0]  offs      = apb_req.paddr[7:0];
    wire        acc       = apb_req.psel & apb_req.penable;
    wire        done      = acc & apb_rsp.pready;
    wire        wr        = done & apb_req.pwrite & ~apb_rsp.pslverr;
    wire [15:0] wd        = apb_req.pwdata[15:0];
    wire        in_range  = (apb_req.paddr[31:8] == 24'h000000) && (offs <= GPC_OFS_F_IN);
    wire        mapped    = in_range && (offs[1:0] == 2'b00);
    wire [15:0] b_dir_eff = {6'h00, b_dir[9:0] & ~b_func};                      // RULE6
    wire [15:0] a_dir_eff = a_ctl1[GPC_PIN15_SEL] ? (a_dir | 16'h8000) : a_dir; // RULE4
    wire [7:0]  f_value   = pf_s2 | adc_sampling;                             // RULE9 RULE10
    wire [15:0] a_out     = a_ctl1[GPC_PIN15_SEL] ? {ck_div, a_data[14:0]} : a_data;

    // **********************************************
    // read mux
    // **********************************************
    logic [15:0] rd_val;
    always_comb begin
        rd_val = 16'h0000;
        unique case (offs)
            GPC_OFS_A_CTL1: rd_val = a_ctl1;
            GPC_OFS_A_CTL2: rd_val = a_ctl2;
            GPC_OFS_B_DIR:  rd_val = b_dir;
            GPC_OFS_B_FUNC: rd_val = {6'h00, b_func};
            GPC_OFS_A_DIR:  rd_val = a_dir;
            GPC_OFS_C_DIR:  rd_val = c_dir;
            GPC_OFS_D_DIR:  rd_val = d_dir;
            GPC_OFS_E_DIR:  rd_val = e_dir;
            GPC_OFS_A_DATA: rd_val = read_port(a_data, a_dir_eff, pa_s2);            // RULE12
            GPC_OFS_B_DATA: rd_val = read_port(b_data, b_dir_eff, {6'h00, pb_s2});
            GPC_OFS_C_DATA: rd_val = read_port(c_data, c_dir, pc_s2);
            GPC_OFS_D_DATA: rd_val = read_port(d_data, d_dir, pd_s2);
            GPC_OFS_E_DATA: rd_val = read_port(e_data, e_dir, pe_s2);
            GPC_OFS_F_IN:   rd_val = {8'h00, f_value};                               // RULE9
            default:        rd_val = 16'h0000;
        endcase
    end

    // **********************************************
    // apb response
    // **********************************************
    wire next_ready = acc & ~apb_rsp.pready;

    always_ff @(posedge sys_clk) begin
        if (!rstn || watchdog_reset_source) begin
            apb_rsp <= '0;
        end else if (clk_en) begin
            apb_rsp.pready  <= next_ready;
            apb_rsp.pslverr <= next_ready & ~mapped;
            if (next_ready) begin
                apb_rsp.prdata <= (mapped && !apb_req.pwrite) ? {16'h0000, rd_val} : 32'h0;
            end
        end
    end

    // **********************************************
    // control registers
    // **********************************************
    always_ff @(posedge sys_clk) begin
        if (!rstn) begin
            a_ctl1 <= mode_s2 ? GPC_CTL1_RST_EXT : GPC_CTL1_RST_SGL;  // RULE1
            a_ctl2 <= GPC_CTL2_RST;                                   // RULE2
        end else if (clk_en && wr) begin                              // RULE3
            if (offs == GPC_OFS_A_CTL1) a_ctl1 <= wd;
            if (offs == GPC_OFS_A_CTL2) a_ctl2 <= wd;
        end
    end

    always_ff @(posedge sys_clk) begin
        if (!rstn) begin
            {a_dir, b_dir, c_dir, d_dir, e_dir} <= {5{GPC_DIR_RST}};
            b_func <= GPC_BFUNC_RST;
        end else if (clk_en && wr) begin
            if (offs == GPC_OFS_B_DIR)  b_dir <= wd;                  // RULE5
            if (offs == GPC_OFS_B_FUNC) b_func <= wd[9:0];
            if (offs == GPC_OFS_A_DIR)  a_dir <= wd;
            if (offs == GPC_OFS_C_DIR)  c_dir <= wd;
            if (offs == GPC_OFS_D_DIR)  d_dir <= wd;
            if (offs == GPC_OFS_E_DIR)  e_dir <= wd;
        end
    end

    // **********************************************
    // data registers
    // **********************************************
    always_ff @(posedge sys_clk) begin
        if (!rstn) begin                                              // RULE7
            {a_data, b_data, c_data, d_data, e_data} <= {5{GPC_DATA_RST}};
        end else if (clk_en && wr) begin                              // RULE8
            if (offs == GPC_OFS_A_DATA) a_data <= wd;
            if (offs == GPC_OFS_B_DATA) b_data <= wd;
            if (offs == GPC_OFS_C_DATA) c_data <= wd;
            if (offs == GPC_OFS_D_DATA) d_data <= wd;
            if (offs == GPC_OFS_E_DATA) e_data <= wd;
        end
    end

    // **********************************************
    // pin drivers
    // **********************************************
    always_ff @(posedge sys_clk) begin
        if (!rstn) begin
            ck_div <= 1'b0;
            pa_pin <= '0;
            pb_pin <= '0;
            pc_pin <= '0;
            pd_pin <= '0;
            pe_pin <= '0;
        end else if (clk_en) begin
            ck_div <= ~ck_div;
            pa_pin <= {a_out, a_dir_eff};                             // RULE4 RULE12
            pb_pin <= {b_data[9:0], b_dir_eff[9:0]};                  // RULE6
            pc_pin <= {c_data, c_dir};
            pd_pin <= {d_data, d_dir};
            pe_pin <= {e_data, e_dir};
        end
    end

    // **********************************************
    // checks
    // **********************************************
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (1'b0);

    a_ctl1_reset_val: assert property (                                        // RULE1
        !rstn [*3] |=> a_ctl1 == ($past(mode_s2) ? GPC_CTL1_RST_EXT : GPC_CTL1_RST_SGL))
        else $error("control one reset value wrong");

    a_ctl2_reset_clr: assert property (                                        // RULE2
        !rstn |=> a_ctl2 == 16'h0000)
        else $error("control two not cleared by reset");

    a_ctl_keep_wdt: assert property (                                          // RULE3
        rstn && (watchdog_reset_source || standby || sleep) && !wr
        |=> $stable(a_ctl1) && $stable(a_ctl2))
        else $error("control registers lost on watchdog or low power");

    a_pin15_clock: assert property (                                           // RULE4
        rstn && clk_en && a_ctl1[14] ##1 rstn |-> pa_pin.oe[15] && pa_pin.out[15] == $past(ck_div))
        else $error("pin 15 not driven as clock output");

    a_b_dir_write: assert property (                                           // RULE5
        rstn && clk_en && wr && offs == 8'h08 ##1 rstn |-> b_dir == $past(apb_req.pwdata[15:0]))
        else $error("port b direction write lost");

    a_b_dir_gate: assert property (                                            // RULE6
        rstn && clk_en ##1 rstn |-> pb_pin.oe == ($past(b_dir[9:0]) & ~$past(b_func)))
        else $error("port b direction used outside general io");

    a_data_keep: assert property (                                             // RULE7
        rstn && (watchdog_reset_source || standby || sleep) && !wr
        |=> $stable({a_data, b_data, c_data, d_data, e_data}))
        else $error("port data lost on watchdog or low power");

    a_f_write_ignored: assert property (                                       // RULE8
        rstn && wr && offs == 8'h34 |=> $stable({a_data, b_data, c_data, d_data, e_data})
        && $stable({a_dir, b_dir, c_dir, d_dir, e_dir}))
        else $error("write to port f changed state");

    a_f_read_live: assert property (                                           // RULE9
        rstn && !watchdog_reset_source && clk_en && next_ready && mapped && !apb_req.pwrite
        && offs == GPC_OFS_F_IN ##1 rstn
        |-> apb_rsp.prdata == {24'h000000, $past(pf_s2) | $past(adc_sampling)})
        else $error("port f read does not show pins");

    a_f_analog_one: assert property (                                          // RULE10
        rstn && !watchdog_reset_source && clk_en && next_ready && mapped && !apb_req.pwrite
        && offs == GPC_OFS_F_IN && adc_sampling[0] ##1 rstn |-> apb_rsp.prdata[0])
        else $error("sampled analog bit not read as one");

    a_f_mirror: assert property (                                              // RULE11
        clk_en ##1 clk_en |=> pf_s2 == $past(pf_in, 2))
        else $error("port f input does not follow pins in reset");

    a_gpio_out_drive: assert property (                                        // RULE12
        rstn && clk_en && !a_ctl1[14] ##1 rstn |-> pa_pin.out == $past(a_data))
        else $error("port a output not driven from data");

    // **********************************************
    // bus and pin checks
    // **********************************************
    a_rsp_reset_clr: assert property (
        !rstn || watchdog_reset_source |=> !apb_rsp.pready && !apb_rsp.pslverr)
        else $error("bus response not cleared by reset");

    a_ready_one_wait: assert property (
        rstn && !watchdog_reset_source && clk_en && next_ready |=> apb_rsp.pready)
        else $error("access not answered after one wait state");

    a_ready_pulse: assert property (
        clk_en && apb_rsp.pready |=> !apb_rsp.pready)
        else $error("ready held longer than one cycle");

    a_err_unmapped: assert property (
        rstn && !watchdog_reset_source && clk_en && next_ready && !mapped |=> apb_rsp.pslverr)
        else $error("unmapped access not flagged");

    a_err_mapped_clear: assert property (
        rstn && !watchdog_reset_source && clk_en && next_ready && mapped |=> !apb_rsp.pslverr)
        else $error("mapped access flagged as error");

    a_unmapped_read_zero: assert property (
        rstn && !watchdog_reset_source && clk_en && next_ready && !mapped
        |=> apb_rsp.prdata == 32'h00000000)
        else $error("unmapped access returned data");

    a_upper_read_zero: assert property (
        rstn && !watchdog_reset_source && clk_en && next_ready
        |=> apb_rsp.prdata[31:16] == 16'h0000)
        else $error("upper read half not zero");

    a_pins_reset: assert property (
        !rstn |=> {pa_pin, pb_pin, pc_pin, pd_pin, pe_pin} == '0)
        else $error("pins not released by reset");

    a_b_out_drive: assert property (                                           // RULE12
        rstn && clk_en |=> pb_pin.out == $past(b_data[9:0]))
        else $error("port b output not driven from data");

    a_c_pin_drive: assert property (                                           // RULE12
        rstn && clk_en |=> pc_pin == $past({c_data, c_dir}))
        else $error("port c pins not driven from registers");

    a_d_pin_drive: assert property (                                           // RULE12
        rstn && clk_en |=> pd_pin == $past({d_data, d_dir}))
        else $error("port d pins not driven from registers");

    a_e_pin_drive: assert property (                                           // RULE12
        rstn && clk_en |=> pe_pin == $past({e_data, e_dir}))
        else $error("port e pins not driven from registers");

    a_f_bits_one: assert property (                                            // RULE10
        rstn && !watchdog_reset_source && clk_en && next_ready && mapped && !apb_req.pwrite
        && offs == GPC_OFS_F_IN
        |=> (apb_rsp.prdata[7:0] & $past(adc_sampling)) == $past(adc_sampling))
        else $error("sampled analog bits not read as one");

    a_pin15_gpio: assert property (                                            // RULE4
        rstn && clk_en && !a_ctl1[GPC_PIN15_SEL]
        |=> pa_pin.oe[GPC_CLK_PIN] == $past(a_dir[GPC_CLK_PIN]))
        else $error("pin 15 not general io in single chip use");

    a_b_dir_read: assert property (                                            // RULE5
        rstn && !watchdog_reset_source && clk_en && next_ready && mapped && !apb_req.pwrite
        && offs == GPC_OFS_B_DIR |=> apb_rsp.prdata[15:0] == $past(b_dir))
        else $error("port b direction read back wrong");

    a_f_write_ok: assert property (                                            // RULE8
        rstn && !watchdog_reset_source && clk_en && next_ready && mapped && apb_req.pwrite
        && offs == GPC_OFS_F_IN |=> !apb_rsp.pslverr)
        else $error("write to port f flagged as error");

endmodule
`default_nettype wire

//--- rtl/gpc_pkg.sv
// Summary of operation
// RULE1 - An external power-on reset loads the first port A control register with 0x4000 in extended mode and 0x0000 in single-chip mode.
// RULE2 - An external power-on reset clears the second port A control register to 0x0000.
// RULE3 - A watchdog reset, standby or sleep leaves both port A control registers as they were.
// RULE4 - Bit 14 of the first port A control register makes port A pin 15 general I/O at 0 and the clock output at 1.
// RULE5 - The port B direction register is a 16-bit read/write register whose bits 9 to 0 set pins 9 to 0 as input or output.
// RULE6 - A port B direction bit steers its pin only while that pin is in general I/O use.
// RULE7 - The data registers of ports A to E are set only by external power-on reset and survive watchdog reset, standby and sleep.
// RULE8 - The port F input register is 8-bit read-only and writes to it change nothing.
// RULE9 - Each port F input bit reads the live level of the matching port F pin.
// RULE10 - A port F bit whose pin is being sampled as an analog input reads as 1.
// RULE11 - The port F input register has no reset value and always mirrors the pins.
// RULE12 - A general-purpose output pin is driven from its data bit and reading that bit returns the stored value.
package gpc_pkg;

    // **********************************************
    // register offsets (byte addresses)
    // **********************************************
    localparam logic [7:0] GPC_OFS_A_CTL1   = 8'h00;
    localparam logic [7:0] GPC_OFS_A_CTL2   = 8'h04;
    localparam logic [7:0] GPC_OFS_B_DIR    = 8'h08;
    localparam logic [7:0] GPC_OFS_B_FUNC   = 8'h0C;
    localparam logic [7:0] GPC_OFS_A_DIR    = 8'h10;
    localparam logic [7:0] GPC_OFS_C_DIR    = 8'h14;
    localparam logic [7:0] GPC_OFS_D_DIR    = 8'h18;
    localparam logic [7:0] GPC_OFS_E_DIR    = 8'h1C;
    localparam logic [7:0] GPC_OFS_A_DATA   = 8'h20;
    localparam logic [7:0] GPC_OFS_B_DATA   = 8'h24;
    localparam logic [7:0] GPC_OFS_C_DATA   = 8'h28;
    localparam logic [7:0] GPC_OFS_D_DATA   = 8'h2C;
    localparam logic [7:0] GPC_OFS_E_DATA   = 8'h30;
    localparam logic [7:0] GPC_OFS_F_IN     = 8'h34;

    // **********************************************
    // reset values and fields
    // **********************************************
    localparam logic [15:0] GPC_CTL1_RST_EXT = 16'h4000;
    localparam logic [15:0] GPC_CTL1_RST_SGL = 16'h0000;
    localparam logic [15:0] GPC_CTL2_RST     = 16'h0000;
    localparam logic [15:0] GPC_DIR_RST      = 16'h0000;
    localparam logic [15:0] GPC_DATA_RST     = 16'h0000;
    localparam logic [9:0]  GPC_BFUNC_RST    = 10'h000;
    localparam int          GPC_PIN15_SEL    = 14;
    localparam int          GPC_CLK_PIN      = 15;

    // **********************************************
    // carriers
    // **********************************************
    typedef struct packed {
        logic        psel;
        logic        penable;
        logic [31:0] paddr;
        logic        pwrite;
        logic [31:0] pwdata;
    } gpc_apb_req_type;

    typedef struct packed {
        logic [31:0] prdata;
        logic        pready;
        logic        pslverr;
    } gpc_apb_rsp_type;

    typedef struct packed {
        logic [15:0] out;
        logic [15:0] oe;
    } gpc_pin16_type;

    typedef struct packed {
        logic [9:0] out;
        logic [9:0] oe;
    } gpc_pin10_type;

endpackage

//--- bench/gpc_board.sv
`timescale 1ns/1ps
`default_nettype none
// ****************************************
// board side of the shared port pins
// ****************************************
module gpc_board (
    input  wire gpc_pkg::gpc_pin16_type pa_pin,
    input  wire gpc_pkg::gpc_pin10_type pb_pin,
    input  wire logic [15:0]            drv,
    output logic [15:0]                 pa_in,
    output logic [9:0]                  pb_in,
    output logic [7:0]                  pf_in
);
    import gpc_pkg::*;
    // released pins follow the board level
    assign pa_in = (pa_pin.oe & pa_pin.out) | (~pa_pin.oe & drv);
    assign pb_in = (pb_pin.oe & pb_pin.out) | (~pb_pin.oe & drv[9:0]);
    assign pf_in = drv[15:8];
endmodule
`default_nettype wire

//--- bench/gpc_port_tb.sv
`timescale 1ns/1ps
`default_nettype none
// ****************************************
// bench for the port block
// ****************************************
module gpc_port_tb;
    import gpc_pkg::*;
    logic            sys_clk, rstn, clk_en, wd, stby, slp, ext;
    gpc_apb_req_type req;
    gpc_apb_rsp_type rsp;
    gpc_pin16_type   pa_pin, pc_pin, pd_pin, pe_pin;
    gpc_pin10_type   pb_pin;
    logic [15:0]     pa_in, drv, v, d;
    logic [9:0]      pb_in;
    logic [7:0]      pf_in, adc;
    logic [33:0]     expq[$];
    logic [33:0]     e;
    logic [15:0]     dv[4];
    logic [7:0]      dirs[4] = '{GPC_OFS_A_DIR, GPC_OFS_C_DIR, GPC_OFS_D_DIR, GPC_OFS_E_DIR};
    logic [7:0]      dats[4] = '{GPC_OFS_A_DATA, GPC_OFS_C_DATA, GPC_OFS_D_DATA, GPC_OFS_E_DATA};
    int              mismatches, n_tests, seed;

    gpc_port i_dut (.sys_clk(sys_clk), .rstn(rstn), .clk_en(clk_en),
        .watchdog_reset_source(wd), .standby(stby), .sleep(slp), .extended_mode(ext),
        .apb_req(req), .apb_rsp(rsp), .pa_in(pa_in), .pb_in(pb_in), .pc_in(drv),
        .pd_in(drv), .pe_in(drv), .pf_in(pf_in), .adc_sampling(adc), .pa_pin(pa_pin),
        .pb_pin(pb_pin), .pc_pin(pc_pin), .pd_pin(pd_pin), .pe_pin(pe_pin));
    gpc_board i_board (.pa_pin(pa_pin), .pb_pin(pb_pin), .drv(drv), .pa_in(pa_in),
        .pb_in(pb_in), .pf_in(pf_in));

    task automatic summarize();
        if (mismatches == 0 && n_tests > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask
    task automatic check(input string nm, input logic [31:0] ex, input logic [31:0] got);
        n_tests++;
        if (got !== ex) begin
            mismatches++;
            $display("BAD %s exp %h got %h", nm, ex, got);
        end
    endtask
    // ex: {check data, expected error, expected data}
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] wdat,
                       input logic [33:0] ex);
        int n;
        @(posedge sys_clk);
        req <= '{1'b1, 1'b0, {24'h0, a}, w, wdat};
        expq.push_back(ex);
        @(posedge sys_clk);
        req.penable <= 1'b1;
        n = 0;
        do begin
            @(posedge sys_clk);
            n++;
        end while (rsp.pready !== 1'b1 && n < 20);
        if (rsp.pready !== 1'b1) begin
            mismatches++;
            summarize();
        end
        req <= '0;
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] x);
        apb(1'b1, a, x, 34'h0);
    endtask
    task automatic rd(input logic [7:0] a, input logic [31:0] x);
        apb(1'b0, a, 32'h0, {2'b10, x});
    endtask
    task automatic por(input logic m);
        ext <= m;
        rstn <= 1'b0;
        repeat (4) @(posedge sys_clk);
        rstn <= 1'b1;
    endtask

    // ****************************************
    // response watcher
    // ****************************************
    always @(posedge sys_clk) begin
        if (rsp.pready === 1'b1) begin
            if (expq.size() == 0) begin
                check("unexpected_pready", 32'h0, 32'h1);
            end else begin
                e = expq.pop_front();
                check("pslverr", {31'h0, e[32]}, {31'h0, rsp.pslverr});
                if (e[33]) check("prdata", e[31:0], rsp.prdata);
            end
        end
    end

    initial begin
        sys_clk = 1'b0;
        forever #20 sys_clk = ~sys_clk;
    end

    initial begin
        {rstn, wd, stby, slp, ext} = 5'b00001;
        clk_en = 1'b1;
        req = '0;
        drv = 16'hA5C3;
        adc = 8'h00;
        seed = 65;
        mismatches = 0;
        n_tests = 0;
        por(1'b1);
        rd(GPC_OFS_A_CTL1, 32'h4000);
        rd(GPC_OFS_A_CTL2, 32'h0);
        rd(GPC_OFS_F_IN, {24'h0, drv[15:8]});
        @(posedge sys_clk);
        #1 v[0] = pa_pin.out[15];
        @(posedge sys_clk);
        #1 check("pa15_clk", {31'h0, ~v[0]}, {31'h0, pa_pin.out[15]});
        check("pa15_oe", 32'h1, {31'h0, pa_pin.oe[15]});
        @(posedge sys_clk);
        clk_en <= 1'b0;
        @(posedge sys_clk);
        #1 v[1] = pa_pin.out[15];
        @(posedge sys_clk);
        clk_en <= 1'b1;
        #1 check("pa15_frozen", {31'h0, v[1]}, {31'h0, pa_pin.out[15]});
        v = 16'($random(seed));
        d = 16'($random(seed));
        wr(GPC_OFS_B_DIR, {16'h0, v});
        rd(GPC_OFS_B_DIR, {16'h0, v});
        wr(GPC_OFS_B_DATA, {16'h0, d});
        wr(GPC_OFS_A_CTL2, 32'h5A5A);
        repeat (3) @(posedge sys_clk);
        #1 check("pb_oe", {22'h0, v[9:0]}, {22'h0, pb_pin.oe});
        check("pb_out", {22'h0, d[9:0]}, {22'h0, pb_pin.out});
        rd(GPC_OFS_B_DATA, {22'h0, (v[9:0] & d[9:0]) | (~v[9:0] & drv[9:0])});
        wr(GPC_OFS_B_FUNC, 32'h3FF);
        repeat (2) @(posedge sys_clk);
        #1 check("pb_oe_func", 32'h0, {22'h0, pb_pin.oe});
        wr(GPC_OFS_B_FUNC, 32'h0);
        for (int i = 0; i < 4; i++) begin
            dv[i] = 16'($random(seed));
            wr(dirs[i], 32'hFFFF);
            wr(dats[i], {16'h0, dv[i]});
        end
        wd <= 1'b1;
        stby <= 1'b1;
        slp <= 1'b1;
        repeat (3) @(posedge sys_clk);
        {wd, stby, slp} <= 3'b000;
        #1 check("pa_out", {17'h0, dv[0][14:0]}, {17'h0, pa_pin.out[14:0]});
        check("pc_out", {16'h0, dv[1]}, {16'h0, pc_pin.out});
        check("pd_out", {16'h0, dv[2]}, {16'h0, pd_pin.out});
        check("pe_out", {16'h0, dv[3]}, {16'h0, pe_pin.out});
        check("pcde_oe", 32'hFFFF, {16'h0, pc_pin.oe & pd_pin.oe & pe_pin.oe});
        rd(GPC_OFS_A_CTL1, 32'h4000);
        rd(GPC_OFS_A_CTL2, 32'h5A5A);
        for (int i = 0; i < 4; i++) rd(dats[i], {16'h0, dv[i]});
        rd(GPC_OFS_B_DATA, {22'h0, (v[9:0] & d[9:0]) | (~v[9:0] & drv[9:0])});
        wr(GPC_OFS_F_IN, 32'h00FF);
        for (int k = 0; k < 4; k++) begin
            drv <= 16'($random(seed));
            adc <= (k == 0) ? 8'h00 : 8'($random(seed));
            repeat (3) @(posedge sys_clk);
            rd(GPC_OFS_F_IN, {24'h0, drv[15:8] | adc});
        end
        apb(1'b0, 8'h38, 32'h0, {2'b11, 32'h0});
        apb(1'b1, 8'h02, 32'h1, {2'b01, 32'h0});
        por(1'b0);
        rd(GPC_OFS_A_CTL1, 32'h0);
        #1 check("pa15_oe_sgl", 32'h0, {31'h0, pa_pin.oe[15]});
        wr(GPC_OFS_A_DIR, 32'hFFFF);
        rd(GPC_OFS_A_DATA, 32'h0);
        summarize();
    end
endmodule
`default_nettype wire
